// file: src/serial_unit_pkg.sv
// Purpose: Shared constants and types for the universal serial unit.
// Assumes: System clock of 20 MHz; link clock arrives on the clock pin.
// Notes:   Operation summary follows.
//
// Operation
// - One CPU read/write 8-bit shift register.
// - Shift MSB drives one of two pins.
// - Transparent latch moves output to opposite edge.
// - Serial input always from data-in pin.
// - Readable, writable 4-bit counter with overflow.
// - Counter and shifter share one clock source.
// - External clock: counter counts both edges.
// - Clock from pin, timer overflow or software.
// - Two-wire start condition detected, may interrupt.
// - Two-wire wait states hold clock line low.
// - Three-wire is SPI mode 0/1, no select.
// - Linked units exchange bytes after eight clocks.
// - Master clock pin from toggle strobe only.
// - Edge select picks sample and shift edges.
// - Sixteen edges overflow counter, byte complete.
// - Counter overflow wakes processor from idle.
// - Start detector wakes from every sleep mode.
// - Clock limits: /16 two-wire, /2 or /4.
package serial_unit_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int        SHIFT_W   = 8;
    localparam int        CNT_W     = 4;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [3:0] CNT_RST   = 4'h0;
    localparam logic [3:0] CNT_TOP   = 4'hf;
    localparam int        BYTE_EDGES = 16;
    localparam int        SYNC_W    = 6;

    // ------------------------------------------------------------------
    // Clock rates and serial clock limits
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ      = 20_000_000;
    localparam int TWO_WIRE_DIV    = 16;
    localparam int THREE_MASTER_DIV = 2;
    localparam int THREE_SLAVE_DIV  = 4;
    localparam int TWO_WIRE_MAX_HZ = SYS_CLK_HZ / TWO_WIRE_DIV;
    localparam int THREE_SLAVE_MAX_HZ = SYS_CLK_HZ / THREE_SLAVE_DIV;

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WIRE_OFF,
        WIRE_THREE,
        WIRE_TWO
    } wire_mode_t;

    typedef enum logic [1:0] {
        SRC_SOFT,
        SRC_TIMER,
        SRC_EXT
    } clock_src_t;

endpackage

// file: src/sync_bits.sv
// Purpose: Two-stage synchroniser for a group of independent levels.
// Assumes: Each bit is a level or a toggle from another domain.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ns
module sync_bits #(
    parameter int WIDTH = 1
) (
    // Clock
    input  wire logic             clk,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            meta_q[i]  <= asyncIn[i];
            syncOut[i] <= meta_q[i];
        end
    end

endmodule

// file: src/serial_shift_unit.sv
// Purpose: Universal serial unit: shift register, edge counter, clocks.
// Assumes: clk is the 20 MHz system clock; linkClk is the clock pin.
// Notes:   Link edges cross to clk by toggles, so the external clock
//          must stay below a quarter of the system clock.
`timescale 1ns/1ns
module serial_shift_unit
    import serial_unit_pkg::*;
(
    // System clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Link clock (serial clock pin) and pin levels
    input  wire logic             linkClk,
    input  wire logic             dataInPin,
    input  wire logic             clockPinIn,
    // Configuration
    input  wire wire_mode_t       wireMode,
    input  wire clock_src_t       clockSrc,
    input  wire logic             edgeSel,
    input  wire logic             masterEn,
    input  wire logic             waitOnStart,
    input  wire logic             waitOnOvf,
    input  wire logic             ovfIrqEn,
    input  wire logic             startIrqEn,
    // Clock events from software and timer
    input  wire logic             clockStrobe,
    input  wire logic             toggleStrobe,
    input  wire logic             timerOvf,
    // Shift register access
    input  wire logic             shiftWrEn,
    input  wire logic [7:0]       shiftWrData,
    output logic      [7:0]       shiftRdData,
    // Counter access
    input  wire logic             cntWrEn,
    input  wire logic [3:0]       cntWrData,
    output logic      [3:0]       cntRdData,
    // Flags
    output logic                  ovfFlag,
    input  wire logic             ovfClr,
    output logic                  startFlag,
    input  wire logic             startClr,
    output logic                  ovfWake,
    output logic                  startWake,
    // Pins
    output logic                  dataOutPin,
    output logic                  dataLineOut,
    output logic                  dataLineOe,
    output logic                  clockPinOut,
    output logic                  clockPinOe
);

    // ------------------------------------------------------------------
    // Link domain capture
    // ------------------------------------------------------------------
    // Each edge of the link clock captures the data-in level and flips a
    // toggle; the system side sees an edge as a change of that toggle.
    logic       linkRstMeta_q;
    logic       linkRst_q;
    logic       riseBit_q;
    logic       riseTog_q;
    logic       fallBit_q;
    logic       fallTog_q;

    always_ff @(posedge linkClk) begin
        linkRstMeta_q <= srst;
        linkRst_q     <= linkRstMeta_q;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            riseBit_q <= 1'b0;
            riseTog_q <= 1'b0;
        end else begin
            riseBit_q <= dataInPin;
            riseTog_q <= ~riseTog_q;
        end
    end

    always_ff @(negedge linkClk) begin
        if (linkRst_q) begin
            fallBit_q <= 1'b0;
            fallTog_q <= 1'b0;
        end else begin
            fallBit_q <= dataInPin;
            fallTog_q <= ~fallTog_q;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the system domain
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncOut;
    logic [1:0]        togDly_q;
    logic              dataDly_q;
    logic              riseEvt;
    logic              fallEvt;
    logic              sclS;
    logic              sdaS;

    assign syncIn = {clockPinIn, dataInPin, fallBit_q, riseBit_q,
                     fallTog_q, riseTog_q};

    sync_bits #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk     (clk),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            togDly_q  <= 2'h0;
            dataDly_q <= 1'b1;
        end else begin
            togDly_q  <= syncOut[1:0];
            dataDly_q <= syncOut[4];
        end
    end

    assign riseEvt = syncOut[0] ^ togDly_q[0];
    assign fallEvt = syncOut[1] ^ togDly_q[1];
    assign sdaS    = syncOut[4];
    assign sclS    = syncOut[5];

    // ------------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------------
    logic       extSel;
    logic       shiftEvt;
    logic       sampleBit;
    logic [1:0] cntInc;

    assign extSel = (clockSrc == SRC_EXT);

    always_comb begin
        shiftEvt  = 1'b0;
        sampleBit = sdaS;
        cntInc    = 2'h0;
        unique case (clockSrc)
            SRC_SOFT: begin
                shiftEvt = clockStrobe;
                cntInc   = {1'b0, clockStrobe};
            end
            SRC_TIMER: begin
                shiftEvt = timerOvf;
                cntInc   = {1'b0, timerOvf};
            end
            SRC_EXT: begin
                // Mode 0 samples on rising edges, mode 1 on falling.
                shiftEvt  = edgeSel ? fallEvt : riseEvt;
                sampleBit = edgeSel ? syncOut[3] : syncOut[2];
                cntInc    = {1'b0, riseEvt} + {1'b0, fallEvt};
            end
            default: begin
                shiftEvt  = 1'b0;
                sampleBit = sdaS;
                cntInc    = 2'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    logic [7:0] shift_q;

    // One register holds both directions; a received byte is lost if
    // software does not read it before the next transfer starts.
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_q <= SHIFT_RST;
        end else if (shiftWrEn) begin
            shift_q <= shiftWrData;
        end else if (shiftEvt) begin
            shift_q <= {shift_q[6:0], sampleBit};
        end
    end

    assign shiftRdData = shift_q;

    // ------------------------------------------------------------------
    // Edge counter and overflow flag
    // ------------------------------------------------------------------
    logic [3:0] cnt_q;
    logic [4:0] cntSum;
    logic       ovfSet;
    logic       ovf_q;

    assign cntSum = {1'b0, cnt_q} + {3'h0, cntInc};
    assign ovfSet = ~cntWrEn & cntSum[4];

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= CNT_RST;
        end else if (cntWrEn) begin
            cnt_q <= cntWrData;
        end else begin
            cnt_q <= cntSum[3:0];
        end
    end

    // A wrap in the same cycle as a clear keeps the flag set.
    always_ff @(posedge clk) begin
        if (srst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovfSet | (ovf_q & ~ovfClr);
        end
    end

    assign cntRdData = cnt_q;
    assign ovfFlag   = ovf_q;
    assign ovfWake   = ovf_q & ovfIrqEn;

    // ------------------------------------------------------------------
    // Output latch and data pins
    // ------------------------------------------------------------------
    logic latchOpen;
    logic outLatch_q;
    logic dataOut_q;
    logic lineOe_q;
    logic twoWire;

    assign twoWire = (wireMode == WIRE_TWO);

    // On the link clock the latch is open only in the phase after the output edge, so a
    // shift on the sampling edge reaches the pin half a cycle later.
    assign latchOpen = ~extSel | (sclS == edgeSel);

    always_ff @(posedge clk) begin
        if (srst) begin
            outLatch_q <= 1'b0;
        end else if (latchOpen) begin
            outLatch_q <= shift_q[7];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dataOut_q <= 1'b0;
            lineOe_q  <= 1'b0;
        end else begin
            // Three-wire has no select input; framing is software's.
            dataOut_q <= (wireMode == WIRE_THREE) & outLatch_q;
            lineOe_q  <= twoWire & ~outLatch_q;
        end
    end

    assign dataOutPin  = dataOut_q;
    assign dataLineOut = 1'b0;
    assign dataLineOe  = lineOe_q;

    // ------------------------------------------------------------------
    // Two-wire start detector
    // ------------------------------------------------------------------
    logic startDet;
    logic start_q;

    assign startDet = twoWire & dataDly_q & ~sdaS & sclS;

    always_ff @(posedge clk) begin
        if (srst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= startDet | (start_q & ~startClr);
        end
    end

    assign startFlag = start_q;
    assign startWake = start_q & startIrqEn & twoWire;

    // ------------------------------------------------------------------
    // Clock pin: master toggle and wait states
    // ------------------------------------------------------------------
    logic holdLow;
    logic clkTog_q;
    logic clkOut_q;
    logic clkOe_q;

    assign holdLow = twoWire & ((start_q & waitOnStart) |
                                (ovf_q & waitOnOvf));

    always_ff @(posedge clk) begin
        if (srst) begin
            clkTog_q <= 1'b0;
        end else if (toggleStrobe & masterEn) begin
            clkTog_q <= ~clkTog_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clkOut_q <= 1'b0;
            clkOe_q  <= 1'b0;
        end else begin
            clkOut_q <= clkTog_q & ~holdLow;
            clkOe_q  <= masterEn | holdLow;
        end
    end

    assign clockPinOut = clkOut_q;
    assign clockPinOe  = clkOe_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence startSeen;
        startDet ##1 start_q;
    endsequence

    sequence lineHeld;
        holdLow ##1 (clkOe_q && !clkOut_q);
    endsequence

    shift_load_a: assert property (
        @(posedge clk) disable iff (srst)
        shiftWrEn |=> shift_q == $past(shiftWrData))
        else $error("shift register did not take the written byte");

    shift_in_a: assert property (
        @(posedge clk) disable iff (srst)
        (shiftEvt && !shiftWrEn) |=>
            shift_q == {$past(shift_q[6:0]), $past(sampleBit)})
        else $error("shift did not take the data-in bit");

    cnt_track_a: assert property (
        @(posedge clk) disable iff (srst)
        (!extSel && shiftEvt && !cntWrEn) |=>
            cnt_q == $past(cnt_q) + 4'h1)
        else $error("counter did not follow the shift clock");

    both_edges_a: assert property (
        @(posedge clk) disable iff (srst)
        (extSel && (riseEvt != fallEvt) && !cntWrEn) |=>
            cnt_q == $past(cnt_q) + 4'h1)
        else $error("counter missed an external edge");

    ovf_wrap_a: assert property (
        @(posedge clk) disable iff (srst)
        (cnt_q == CNT_TOP && cntInc != 2'h0 && !cntWrEn) |=>
            ovf_q && cnt_q != CNT_TOP)
        else $error("counter wrap did not raise overflow");

    ovf_sticky_a: assert property (
        @(posedge clk) disable iff (srst)
        (ovf_q && !ovfClr) |=> ovf_q [*1])
        else $error("overflow flag dropped without a clear");

    latch_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        !latchOpen |=> $stable(outLatch_q))
        else $error("output latch changed while closed");

    data_route_a: assert property (
        @(posedge clk) disable iff (srst)
        (wireMode == WIRE_THREE) |=> dataOutPin == $past(outLatch_q))
        else $error("MSB not routed to the data-out pin");

    start_set_a: assert property (
        @(posedge clk) disable iff (srst)
        startDet |-> startSeen)
        else $error("start condition not flagged");

    wait_low_a: assert property (
        @(posedge clk) disable iff (srst)
        holdLow |-> lineHeld)
        else $error("clock line not held low during wait");

    master_tog_a: assert property (
        @(posedge clk) disable iff (srst)
        (toggleStrobe && masterEn) |=> clkTog_q != $past(clkTog_q))
        else $error("clock toggle strobe ignored");

endmodule

// file: sim/spi_peer_model.sv
// Purpose: Behavioural SPI master peer facing the serial unit's pins.
// Assumes: Clock idles low; a half period spans twelve 32 ns grid steps.
// Notes:   The link clock stands still between frames and runs free
//          while reset is held and a few cycles after, so the link
//          side both enters and leaves reset on its own edges.
`timescale 1ns/1ns
module spi_peer_model (
    // Link pins
    output logic      linkClk,
    output logic      dataIn,
    input  wire logic dataOut,
    // Reset helper
    input  wire logic rstRun
);
    // ------------------------------------------------------------------
    // Phase grid
    // ------------------------------------------------------------------
    logic base;
    logic resClk;
    logic frameClk;
    int   tail = 0;

    assign linkClk = (rstRun || tail > 0) ? resClk : frameClk;

    initial begin
        base = 1'b0;
        resClk = 1'b0;
        frameClk = 1'b0;
        dataIn = 1'b1;
        #7;
        forever #16 base = ~base;
    end

    always @(posedge base) begin
        tail <= rstRun ? 8 : ((tail > 0) ? tail - 1 : 0);
        resClk <= (rstRun || tail > 0) ? ~resClk : 1'b0;
    end

    // ------------------------------------------------------------------
    // Byte exchange
    // ------------------------------------------------------------------
    // A slow half period leaves the unit time to cross each edge.
    task automatic half();
        repeat (12) @(posedge base);
    endtask

    task automatic exchange(input logic mode, input logic [7:0] tx,
                            output logic [7:0] rx);
        rx = 8'h00;
        dataIn = tx[7];
        half();
        for (int i = 7; i >= 0; i--) begin
            frameClk = 1'b1;
            if (mode) begin
                #2 dataIn = tx[i];
            end else begin
                rx[i] = dataOut;
            end
            half();
            frameClk = 1'b0;
            if (mode) begin
                rx[i] = dataOut;
            end else if (i > 0) begin
                #2 dataIn = tx[i-1];
            end
            half();
        end
        // Released data line must not keep its last level.
        dataIn = ~dataIn;
    endtask
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for the universal serial unit.
// Assumes: 20 MHz system clock; peer model drives the link clock.
// Notes:   Expected values come from a small integer model kept here.
`timescale 1ns/1ns
module tb
    import serial_unit_pkg::*;
;
    logic       clk, srst, pinHigh, useModel, benchDin, linkClk, peerDin;
    wire_mode_t wireMode;
    clock_src_t clockSrc;
    logic       edgeSel, masterEn, waitOnStart, waitOnOvf, ovfIrqEn;
    logic       startIrqEn, clockStrobe, toggleStrobe, timerOvf;
    logic       shiftWrEn, cntWrEn, ovfClr, startClr;
    logic [7:0] shiftWrData, shiftRdData, expShift, tx, rx, ld;
    logic [3:0] cntWrData, cntRdData, expCnt, c;
    logic       ovfFlag, startFlag, ovfWake, startWake, dataOutPin;
    logic       dataLineOut, dataLineOe, clockPinOut, clockPinOe, expOvf;
    int         error_cnt, total_checks;
    integer     seed = 32'h06913404;
    // Open-drain lines take the unit's level while its output enable is set, else the peer or bench level.
    wire        clockPinIn = clockPinOe ? clockPinOut : (linkClk | pinHigh);
    wire        dinPin = dataLineOe ? 1'b0 : (useModel ? peerDin : benchDin);

    serial_shift_unit dut (.clk(clk), .srst(srst), .linkClk(linkClk),
        .dataInPin(dinPin), .clockPinIn(clockPinIn), .wireMode(wireMode),
        .clockSrc(clockSrc), .edgeSel(edgeSel), .masterEn(masterEn),
        .waitOnStart(waitOnStart), .waitOnOvf(waitOnOvf),
        .ovfIrqEn(ovfIrqEn), .startIrqEn(startIrqEn),
        .clockStrobe(clockStrobe), .toggleStrobe(toggleStrobe),
        .timerOvf(timerOvf), .shiftWrEn(shiftWrEn),
        .shiftWrData(shiftWrData), .shiftRdData(shiftRdData),
        .cntWrEn(cntWrEn), .cntWrData(cntWrData), .cntRdData(cntRdData),
        .ovfFlag(ovfFlag), .ovfClr(ovfClr), .startFlag(startFlag),
        .startClr(startClr), .ovfWake(ovfWake), .startWake(startWake),
        .dataOutPin(dataOutPin), .dataLineOut(dataLineOut),
        .dataLineOe(dataLineOe), .clockPinOut(clockPinOut),
        .clockPinOe(clockPinOe));

    spi_peer_model peer (.linkClk(linkClk), .dataIn(peerDin),
        .dataOut(dataOutPin), .rstRun(srst));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic go(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One CPU-side operation; kind 4 strobes the source not selected.
    task automatic op(input int kind);
        logic [7:0] wd;
        logic [3:0] wc;
        logic       d, en, cnt;
        wd = 8'($random(seed));
        wc = 4'($random(seed));
        d = 1'($random(seed));
        en = 1'($random(seed));
        go(1);
        benchDin <= d;
        ovfIrqEn <= en;
        go(4);
        cnt = (kind < 4) || (kind == 5) || (kind == 6);
        clockStrobe <= (clockSrc == SRC_SOFT) ? cnt : (kind == 4);
        timerOvf <= (clockSrc == SRC_TIMER) ? cnt : (kind == 4);
        shiftWrEn <= (kind == 5);
        cntWrEn <= (kind == 5) || (kind == 7);
        shiftWrData <= wd;
        cntWrData <= wc;
        ovfClr <= (kind == 6);
        go(1);
        {clockStrobe, timerOvf, shiftWrEn, cntWrEn, ovfClr} <= 5'h00;
        if (kind == 6) expOvf = 1'b0;
        if (cnt && kind != 5) begin
            expShift = {expShift[6:0], d};
            expOvf = expOvf | (expCnt == CNT_TOP);
            expCnt = expCnt + 4'h1;
        end
        if (kind == 5) expShift = wd;
        if (kind == 5 || kind == 7) expCnt = wc;
        @(negedge clk);
        chk8(shiftRdData, expShift);
        chk8({4'h0, cntRdData}, {4'h0, expCnt});
        chk1(ovfFlag, expOvf);
        chk1(ovfWake, expOvf & en);
        repeat (2) @(negedge clk);
        chk1(dataOutPin, expShift[7]);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {srst, useModel} = 2'b11;
        {pinHigh, benchDin, edgeSel, masterEn, waitOnStart} = 5'h00;
        {waitOnOvf, ovfIrqEn, startIrqEn, clockStrobe} = 4'h0;
        {toggleStrobe, timerOvf, shiftWrEn, cntWrEn, ovfClr} = 5'h00;
        startClr = 1'b0;
        wireMode = WIRE_THREE;
        clockSrc = SRC_SOFT;
        shiftWrData = 8'h00;
        cntWrData = 4'h0;
        go(20);
        srst <= 1'b0;
        go(4);
        chk8(shiftRdData, SHIFT_RST);
        chk8({4'h0, cntRdData}, {4'h0, CNT_RST});
        {expShift, expCnt, expOvf} = {SHIFT_RST, CNT_RST, 1'b0};
        for (int t = 0; t < 2; t++) begin
            masterEn <= 1'b1;
            toggleStrobe <= 1'b1;
            go(1);
            toggleStrobe <= 1'b0;
            go(1);
            @(negedge clk);
            chk1(clockPinOut, t == 0);
            chk1(clockPinOe, 1'b1);
            go(1);
        end
        masterEn <= 1'b0;
        useModel <= 1'b0;
        for (int j = 0; j < 60; j++) begin
            if (j % 30 == 0) begin
                go(1);
                clockSrc <= j ? SRC_TIMER : SRC_SOFT;
            end
            op($unsigned($random(seed)) % 8);
        end
        for (int k = 0; k < 4; k++) begin
            tx = 8'($random(seed));
            ld = 8'($random(seed));
            c = (k < 2) ? 4'h0 : 4'($random(seed));
            go(1);
            {useModel, ovfIrqEn, edgeSel} <= {2'b11, k[0]};
            clockSrc <= SRC_EXT;
            {shiftWrEn, cntWrEn, ovfClr} <= 3'b111;
            shiftWrData <= ld;
            cntWrData <= c;
            go(1);
            {shiftWrEn, cntWrEn, ovfClr} <= 3'b000;
            go(2);
            peer.exchange(k[0], tx, rx);
            go(8);
            @(negedge clk);
            chk8(shiftRdData, tx);
            chk8(rx, ld);
            chk8({4'h0, cntRdData}, {4'h0, c});
            chk1(ovfFlag, 1'b1);
            chk1(ovfWake, 1'b1);
        end
        go(1);
        {useModel, benchDin, pinHigh, startIrqEn, shiftWrEn} <= 5'h0f;
        wireMode <= WIRE_TWO;
        clockSrc <= SRC_SOFT;
        shiftWrData <= 8'h80;
        go(1);
        shiftWrEn <= 1'b0;
        go(4);
        benchDin <= 1'b0;
        go(6);
        @(negedge clk);
        chk1(dataOutPin, 1'b0);
        chk1(dataLineOe, 1'b0);
        chk1(startFlag, 1'b1);
        chk1(startWake, 1'b1);
        go(1);
        waitOnStart <= 1'b1;
        go(2);
        @(negedge clk);
        chk1(clockPinOe, 1'b1);
        chk1(clockPinOut, 1'b0);
        go(1);
        {startClr, waitOnStart, pinHigh, benchDin} <= 4'h9;
        go(1);
        startClr <= 1'b0;
        go(4);
        {shiftWrEn, cntWrEn, clockStrobe, waitOnOvf} <= 4'hf;
        {shiftWrData, cntWrData} <= {8'h3f, CNT_TOP};
        go(1);
        {shiftWrEn, cntWrEn, clockStrobe} <= 3'b001;
        go(1);
        {cntWrEn, clockStrobe} <= 2'b00;
        go(3);
        @(negedge clk);
        chk1(startFlag, 1'b0);
        chk1(dataLineOe, 1'b1);
        chk1(dataLineOut, 1'b0);
        chk1(ovfFlag, 1'b1);
        chk1(clockPinOe, 1'b1);
        chk1(clockPinOut, 1'b0);
        print_verdict();
    end

    initial begin
        error_cnt = 0;
        total_checks = 0;
        go(40000);
        error_cnt++;
        print_verdict();
    end
endmodule
